// File: uvep_pkg.sv
// Purpose: Shared constants and types for the EPROM programming host
// Assumes: 25 MHz clock, 16K x 8 part driven at pin level
// Notes:   Pin group travels as one packed struct
package uvep_pkg;
   localparam int unsigned ADDR_W        = 14;          // Location inputs width
   localparam int unsigned DATA_W        = 8;           // Byte lines width
   localparam int unsigned CLK_NS        = 40;          // Clock period in ns
   localparam int unsigned PULSE_US      = 100;         // Program pulse width in us
   localparam int unsigned PULSE_CYC     = (PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SETTLE_CYC    = 4;           // Access settle time in cycles
   localparam logic [7:0]  MAX_PULSES    = 8'h19;       // Pulse limit per location
   localparam logic [13:0] LAST_LOC      = 14'h3FFF;    // Final location
   localparam logic [13:0] ID_LOC_BASE   = 14'h0200;    // Identification line bit set
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;       // Erased contents
   localparam logic [12:0] PULSE_CYC_W   = 13'(PULSE_CYC);
   localparam logic [12:0] SETTLE_CYC_W  = 13'(SETTLE_CYC);

   // Pins driven toward the device
   typedef struct packed {
      logic        chip_select_n;
      logic        output_enable_n;
      logic        program_strobe_n;
      logic        vpp_high;        // Programming supply raised
      logic        vcc_raised;      // Core supply at programming level
      logic        id_high_voltage; // Identification voltage on identification_line
      logic [13:0] location_inputs;
      logic [7:0]  byte_lines_out;
      logic [7:0]  byte_lines_oe;
   } uvep_pins_type;

   // Host controller states
   typedef enum logic [8:0] {
      ST_IDLE    = 9'h001,
      ST_READ    = 9'h002,
      ST_PULSE   = 9'h004,
      ST_GAP     = 9'h008,
      ST_VERIFY  = 9'h010,
      ST_NEXT    = 9'h020,
      ST_FINAL   = 9'h040,
      ST_ID      = 9'h080,
      ST_DONE    = 9'h100
   } uvep_state_type;

   // Operations requested by the user side
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_PROG = 2'h1,
      OP_ID   = 2'h2
   } uvep_op_type;
endpackage

// File: uvep_host.sv
// Purpose: Host that reads, programs and identifies a 16K x 8 UV EPROM
// Assumes: Pins driven directly; byte lines sampled through two flops
// Notes:   Programming writes one source byte to every location
`timescale 1ns/1ps
module uvep_host
   import uvep_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    start,        // One-cycle request pulse
   input  wire uvep_pkg::uvep_op_type   op,           // Operation for the request
   input  wire logic [13:0]             loc_in,       // Location for a read
   input  wire logic [7:0]              prog_byte,    // Byte to program everywhere
   input  wire logic [7:0]              byte_lines_in,// Byte lines from the device
   output uvep_pkg::uvep_pins_type      pins,         // Device pin group
   output logic                         busy,         // Operation running
   output logic                         done,         // One-cycle completion pulse
   output logic                         fail,         // Program or parity failure
   output logic [7:0]                   rd_byte,      // Last byte read
   output logic [7:0]                   id_maker,     // Maker byte
   output logic [7:0]                   id_device     // Device byte
);
   // Whole state of the host
   typedef struct packed {
      uvep_state_type state;
      uvep_pins_type  pins;
      logic [12:0]    cnt;
      logic [7:0]     pulses;
      logic [7:0]     data;
      logic           fin;
      logic           busy;
      logic           done;
      logic           fail;
      logic [7:0]     rd;
      logic [7:0]     maker;
      logic [7:0]     dev;
      logic [7:0]     sync1;
      logic [7:0]     sync2;
   } uvep_regs_type;

   uvep_regs_type r_q;   // Registered state
   uvep_regs_type r_d;   // Next state

   // Odd parity check used for both identification bytes
   function automatic logic odd_ok(input logic [7:0] b);
      odd_ok = ^b;
   endfunction

   // Idle pin levels: deselected, outputs off, supplies nominal
   function automatic uvep_pins_type idle_pins();
      uvep_pins_type p;
      p = '0;
      p.chip_select_n    = 1'b1;
      p.output_enable_n  = 1'b1;
      p.program_strobe_n = 1'b1;
      idle_pins = p;
   endfunction

   // Next-state logic
   always_comb begin
      r_d       = r_q;
      r_d.sync1 = byte_lines_in;
      r_d.sync2 = r_q.sync1;
      r_d.done  = 1'b0;
      r_d.cnt   = (r_q.cnt != 13'h0000) ? r_q.cnt - 13'h0001 : 13'h0000;
      case (r_q.state)
         ST_IDLE: begin
            r_d.pins = idle_pins();
            if (start) begin
               r_d.busy = 1'b1;
               r_d.fail = 1'b0;
               r_d.cnt  = SETTLE_CYC_W;
               r_d.pins.chip_select_n   = 1'b0;
               r_d.pins.output_enable_n = 1'b0;
               if (op == OP_PROG) begin
                  r_d.data                   = prog_byte;
                  r_d.fin                    = 1'b0;
                  r_d.pulses                 = 8'h00;
                  r_d.pins                   = idle_pins();
                  r_d.pins.location_inputs   = 14'h0000;
                  r_d.pins.vpp_high          = 1'b1;
                  r_d.pins.vcc_raised        = 1'b1;
                  r_d.state                  = ST_GAP;
               end else if (op == OP_ID) begin
                  r_d.pins.id_high_voltage = 1'b1;
                  r_d.pins.location_inputs = ID_LOC_BASE;
                  r_d.state                = ST_ID;
               end else begin
                  r_d.pins.location_inputs = loc_in;
                  r_d.state                = ST_READ;
               end
            end
         end
         ST_READ: begin
            if (r_q.cnt == 13'h0000) begin
               r_d.rd    = r_q.sync2;
               r_d.state = ST_DONE;
            end
         end
         ST_GAP: begin
            // Select and strobe low with supply raised: program pulse
            if (r_q.cnt == 13'h0000) begin
               r_d.pins.output_enable_n  = 1'b1;
               r_d.pins.byte_lines_out   = r_q.data;
               r_d.pins.byte_lines_oe    = 8'hFF;
               r_d.pins.chip_select_n    = 1'b0;
               r_d.pins.program_strobe_n = 1'b0;
               r_d.pulses                = r_q.pulses + 8'h01;
               // Zero count is the last pulse cycle, so load one less
               r_d.cnt                   = PULSE_CYC_W - 13'h0001;
               r_d.state                 = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (r_q.cnt == 13'h0000) begin
               r_d.pins.program_strobe_n = 1'b1;
               r_d.pins.byte_lines_oe    = 8'h00;
               r_d.pins.output_enable_n  = 1'b0;
               r_d.cnt                   = SETTLE_CYC_W;
               r_d.state                 = ST_VERIFY;
            end
         end
         ST_VERIFY: begin
            if (r_q.cnt == 13'h0000) begin
               r_d.pins.output_enable_n = 1'b1;
               r_d.pins.chip_select_n   = 1'b1;
               r_d.cnt                  = SETTLE_CYC_W;
               if (r_q.sync2 == r_q.data) begin
                  r_d.pulses = 8'h00;
                  r_d.state  = ST_NEXT;
               // A wanted one that reads as zero can never come back
               end else if (r_q.pulses >= MAX_PULSES || (r_q.data & ~r_q.sync2) != 8'h00) begin
                  r_d.fail  = 1'b1;
                  r_d.state = ST_DONE;
               end else begin
                  r_d.state = ST_GAP;
               end
            end
         end
         ST_NEXT: begin
            if (r_q.pins.location_inputs == LAST_LOC) begin
               r_d.pins                 = idle_pins();
               r_d.pins.chip_select_n   = 1'b0;
               r_d.pins.output_enable_n = 1'b0;
               r_d.pins.location_inputs = 14'h0000;
               r_d.cnt                  = SETTLE_CYC_W;
               r_d.state                = ST_FINAL;
            end else begin
               r_d.pins.location_inputs = r_q.pins.location_inputs + 14'h0001;
               r_d.state                = ST_GAP;
            end
         end
         ST_FINAL: begin
            // Nominal supply re-verify of every location
            if (r_q.cnt == 13'h0000) begin
               r_d.cnt = SETTLE_CYC_W;
               if (r_q.sync2 != r_q.data) begin
                  r_d.fail  = 1'b1;
                  r_d.state = ST_DONE;
               end else if (r_q.pins.location_inputs == LAST_LOC) begin
                  r_d.state = ST_DONE;
               end else begin
                  r_d.pins.location_inputs = r_q.pins.location_inputs + 14'h0001;
               end
            end
         end
         ST_ID: begin
            if (r_q.cnt == 13'h0000) begin
               if (r_q.pins.location_inputs[0] == 1'b0) begin
                  r_d.maker                   = r_q.sync2;
                  r_d.fail                    = ~odd_ok(r_q.sync2);
                  r_d.pins.location_inputs[0] = 1'b1;
                  r_d.cnt                     = SETTLE_CYC_W;
               end else begin
                  r_d.dev   = r_q.sync2;
                  r_d.fail  = r_q.fail | ~odd_ok(r_q.sync2);
                  r_d.state = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            r_d.pins  = idle_pins();
            r_d.busy  = 1'b0;
            r_d.done  = 1'b1;
            r_d.state = ST_IDLE;
         end
         default: begin
            r_d.state = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_q       <= '0;
         r_q.state <= ST_IDLE;
         r_q.pins  <= idle_pins();
      end else begin
         r_q <= r_d;
      end
   end

   assign pins      = r_q.pins;
   assign busy      = r_q.busy;
   assign done      = r_q.done;
   assign fail      = r_q.fail;
   assign rd_byte   = r_q.rd;
   assign id_maker  = r_q.maker;
   assign id_device = r_q.dev;

   // Strobe low only with select low and supply raised
   prog_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
      !r_q.pins.program_strobe_n |-> (!r_q.pins.chip_select_n && r_q.pins.vpp_high))
      else $error("program strobe without select and supply");
   // Byte lines only driven while output enable high
   no_fight_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r_q.pins.byte_lines_oe != 8'h00) |-> r_q.pins.output_enable_n)
      else $error("host drives byte lines while device may drive");
   // Pulse stays low for at least 8 cycles, not its full width
   pulse_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(r_q.pins.program_strobe_n) |-> !r_q.pins.program_strobe_n [*8])
      else $error("program pulse too short");
   // Verify follows pulse with enable low, strobe high
   verify_lv_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(r_q.pins.program_strobe_n) |-> !r_q.pins.output_enable_n
         && !r_q.pins.chip_select_n && r_q.pins.vpp_high)
      else $error("verify levels wrong");
   // Identification keeps other location inputs low
   id_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      r_q.pins.id_high_voltage |-> (r_q.pins.location_inputs[13:1] == ID_LOC_BASE[13:1]))
      else $error("location inputs not low in identification");
   // Final pass at nominal supply
   final_nom_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r_q.state == ST_FINAL) |-> !r_q.pins.vcc_raised && !r_q.pins.vpp_high)
      else $error("final verify not at nominal supply");
   // Whole byte driven during pulse
   byte_all_a: assert property (@(posedge clk) disable iff (!rst_n)
      !r_q.pins.program_strobe_n |-> r_q.pins.byte_lines_oe == 8'hFF)
      else $error("byte not fully driven");
   // Idle is deselected
   idle_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r_q.state == ST_IDLE && !$past(start)) |-> r_q.pins.chip_select_n)
      else $error("idle host leaves device selected");
endmodule

// File: uvep_eprom_model.sv
// Purpose: Pin-level model of the 16K x 8 UV EPROM beside the host
// Assumes: Host pins arrive as the package pin struct; byte lines resolved outside
// Notes:   Identity bytes are arbitrary odd-parity values; bad_id spoils parity
`timescale 1ns/1ps
module uvep_eprom_model
   import uvep_pkg::*;
#(
   parameter logic [7:0] MAKER_BYTE  = 8'h23, // Arbitrary value
   parameter logic [7:0] DEVICE_BYTE = 8'h8C  // Arbitrary value
)
(
   input  uvep_pkg::uvep_pins_type pins,       // Pins from the host
   input  wire logic [7:0]         byte_lines, // Resolved byte lines
   input  wire logic               bad_id,     // Even parity on the maker byte
   output logic                    dev_oe,     // Device drives the byte lines
   output logic [7:0]              dev_out     // Value the device presents
);
   logic [7:0] mem [0:16383]; // Storage array
   logic [7:0] last_q;        // Last driven byte
   logic       id_sel;        // Identification decode
   // Erased array reads all ones
   initial begin
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      last_q = 8'h00;
   end
   // Program mode can only clear bits
   always @(pins or byte_lines) begin
      if (!pins.chip_select_n && !pins.program_strobe_n && pins.vpp_high) begin
         mem[pins.location_inputs] = mem[pins.location_inputs] & byte_lines;
      end
   end
   // Output gating and identification decode
   always @* begin
      dev_oe = !pins.chip_select_n && !pins.output_enable_n;
      id_sel = pins.id_high_voltage && (pins.location_inputs[13:1] == 13'h0100);
      if (!dev_oe) dev_out = ~last_q; // Floating lines show no stale value
      else if (!id_sel) dev_out = mem[pins.location_inputs];
      else if (pins.location_inputs[0]) dev_out = DEVICE_BYTE;
      else dev_out = MAKER_BYTE ^ {bad_id, 7'h00};
   end
   // Remember the last driven byte
   always @(dev_out) begin
      if (dev_oe) last_q = dev_out;
   end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the EPROM host against the pin model
// Assumes: Inputs change 1 ns after the rising edge; full programming is too long
// Notes:   Programming is watched over its first pulse, then reset mid-run
`timescale 1ns/1ps
module tb_top;
   import uvep_pkg::*;
   localparam logic [7:0] MAKER  = 8'h23; // Arbitrary value
   localparam logic [7:0] DEVICE = 8'h8C; // Arbitrary value
   logic          clk = 1'b0, rst_n = 1'b0, start = 1'b0, bad_id = 1'b0;
   uvep_op_type   op = OP_READ;
   logic [13:0]   loc_in = 14'h0000, a;
   logic [7:0]    prog_byte = 8'h00, v, v_last, byte_lines, dev_out, rd_byte, id_maker, id_device;
   uvep_pins_type pins;
   logic          busy, done, fail, dev_oe;
   integer        seed = 12728;
   int            err_count = 0, n_checks = 0, i, n;
   // Byte lines resolved from the host's enable alone; undriven bits take the device value
   assign byte_lines = (pins.byte_lines_oe & pins.byte_lines_out) | (~pins.byte_lines_oe & dev_out);
   uvep_host DUT (.clk(clk), .rst_n(rst_n), .start(start), .op(op), .loc_in(loc_in),
      .prog_byte(prog_byte), .byte_lines_in(byte_lines), .pins(pins), .busy(busy),
      .done(done), .fail(fail), .rd_byte(rd_byte), .id_maker(id_maker), .id_device(id_device));
   uvep_eprom_model #(.MAKER_BYTE(MAKER), .DEVICE_BYTE(DEVICE)) MDL (.pins(pins),
      .byte_lines(byte_lines), .bad_id(bad_id), .dev_oe(dev_oe), .dev_out(dev_out));
   // Clock at 25 MHz
   always #20 clk = ~clk;
   // Compare one byte result
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   // Expected byte after programming an erased or partly cleared byte
   function automatic logic [7:0] exp_prog(input logic [7:0] old, input logic [7:0] b);
      return old & b;
   endfunction
   // Issue one request; dbl holds start a second cycle while busy
   task automatic run_op(input uvep_op_type o, input logic [13:0] l, input logic [7:0] b,
                         input logic dbl);
      int k;
      @(posedge clk);
      #1 start = 1'b1;
      op = o;
      loc_in = l;
      prog_byte = b;
      @(posedge clk);
      #1 start = dbl;
      op = OP_ID;
      @(posedge clk);
      #1 start = 1'b0;
      for (k = 0; k < 3000 && done !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk8({7'h00, done}, 8'h01);
   endtask
   // Ending point of every run
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Wire monitor: no contention, identification address kept clean
   always @(negedge clk) begin
      if (rst_n) begin
         chk8({7'h00, dev_oe & (|pins.byte_lines_oe)}, 8'h00);
         if (pins.id_high_voltage) chk8({7'h00, |(pins.location_inputs & ~14'h0201)}, 8'h00);
      end
   end
   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      err_count++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      for (i = 0; i < 12; i++) begin
         a = (i == 0) ? 14'h0000 : (i == 1) ? LAST_LOC : 14'($random(seed)) | 14'h0001;
         v = (i == 0) ? 8'hFF : 8'($random(seed));
         if (i != 0) MDL.mem[a] = v;
         if (i == 1) v_last = v;
         run_op(OP_READ, a, 8'h00, i == 0);
         chk8(rd_byte, v);
         chk8({7'h00, pins.chip_select_n}, 8'h01);
         if (i == 0) chk8(id_maker, 8'h00);
      end
      $display("test read done");
      run_op(OP_ID, 14'h0000, 8'h00, 1'b0);
      chk8(id_maker, MAKER);
      chk8(id_device, DEVICE);
      chk8({6'h00, ^id_maker, ^id_device}, 8'h03);
      chk8({7'h00, fail}, 8'h00);
      bad_id = 1'b1;
      run_op(OP_ID, 14'h0000, 8'h00, 1'b0);
      chk8({7'h00, fail}, 8'h01);
      bad_id = 1'b0;
      $display("test identification done");
      v = 8'($random(seed));
      @(posedge clk);
      #1 start = 1'b1;
      op = OP_PROG;
      prog_byte = v;
      @(posedge clk);
      #1 start = 1'b0;
      // Pins are looked at 1 ns after each edge, once they have settled
      for (n = 0; n < 100 && pins.program_strobe_n !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk8({5'h00, pins.chip_select_n, pins.vpp_high, pins.vcc_raised}, 8'h03);
      chk8(pins.byte_lines_oe, 8'hFF);
      chk8(pins.byte_lines_out, v);
      chk8({7'h00, pins.location_inputs != 14'h0000}, 8'h00);
      for (n = 0; n < 5000 && pins.program_strobe_n === 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk8({7'h00, n != PULSE_CYC}, 8'h00);
      for (n = 0; n < 20 && pins.output_enable_n !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk8({5'h00, pins.chip_select_n, pins.program_strobe_n, pins.vpp_high}, 8'h03);
      chk8(pins.byte_lines_oe, 8'h00);
      chk8(MDL.mem[0], exp_prog(8'hFF, v));
      // Verify passes, so the next pulse lands on the next location
      for (n = 0; n < 100 && pins.program_strobe_n !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk8({2'h0, pins.location_inputs[13:8]}, 8'h00);
      chk8(pins.location_inputs[7:0], 8'h01);
      chk8({7'h00, pins.vcc_raised}, 8'h01);
      $display("test program pulse done");
      // Reset lands two cycles into the second pulse
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk8({4'h0, pins.chip_select_n, pins.output_enable_n, pins.program_strobe_n,
               pins.vpp_high}, 8'h0E);
      chk8(pins.byte_lines_oe, 8'h00);
      chk8({7'h00, busy}, 8'h00);
      rst_n = 1'b1;
      run_op(OP_READ, LAST_LOC, 8'h00, 1'b0);
      chk8(rd_byte, v_last);
      $display("test reset recovery done");
      // A cleared location cannot take a byte with ones in it
      v = 8'($random(seed)) | 8'h01;
      MDL.mem[0] = 8'h00;
      run_op(OP_PROG, 14'h0000, v, 1'b0);
      chk8({7'h00, fail}, {7'h00, exp_prog(8'h00, v) != v});
      chk8(MDL.mem[0], exp_prog(8'h00, v));
      chk8({7'h00, busy}, 8'h00);
      $display("test program failure done");
      finish_test();
   end
endmodule
